// file: hw/fbp_ctrl.sv
// bus mode, command sequencing and sector protection of a two-bank flash
// Notes on behaviour
// - reads of one bank proceed while the other bank programs or erases
// - erase suspend allows reads/programs outside the sectors being erased
// - bypass mode programs a word in two write cycles instead of four
// - erase one sector, several sectors, or the whole array
// - two banks picked by top address bits; boot sectors in bank A
// - large sectors span 32K words on aligned boundaries from zero
// - high programming voltage forces bypass mode and lifts sector locks
// - ID mode returns internal codes on the low data byte
// - deselected outputs float; next read waits the select access time
// - deselect never aborts a running program or erase
// - sleep after stable address for access time plus 60 ns; data held
// - hardware reset aborts, floats outputs, ignores cycles, returns to read
// - ready after long or short ready time, and after recovery time
// - output enable high floats the data lines
// - erase, and program outside bypass mode, need unlock cycles first
// - per-sector lock bits block program and erase
// - write guard low locks outer two sectors; low supply pin locks all
// - supply lockout rejects writes, aborts work and returns to read
// - write cycle only with select and write strobe low, output enable high
// - address taken on strobe rising edge, data on write strobe rising edge
// - wrong or misordered command cycle abandons sequence to read
`timescale 1ns/1ps
module fbp_ctrl #(
    parameter int unsigned ERASE_WIN_CYC = fbp_pkg::ERASE_WIN_DEF
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rst_n,
    input  wire fbp_pkg::fbp_pins_type             pins,
    input  wire logic                              hw_reset_n,
    input  wire logic                              wp_n,
    input  wire logic                              high_program_voltage,
    input  wire logic                              vpp_low,
    input  wire logic                              supply_lockout_level,
    output logic [fbp_pkg::DATA_W-1:0]             adq_out,
    output logic                                   adq_oe_n,
    output logic [fbp_pkg::ADDR_W-1:0]             array_rd_addr,
    input  wire logic [fbp_pkg::DATA_W-1:0]        array_rd_data,
    output fbp_pkg::fbp_op_type                    core_op,
    output logic                                   core_start,
    output logic [fbp_pkg::NUM_SECT-1:0]           core_erase_map,
    output logic                                   core_suspend,
    output logic                                   core_abort,
    input  wire logic                              core_prog_done,
    input  wire logic                              core_erase_done,
    output logic                                   sleep_active,
    output logic                                   standby_active,
    output logic                                   ready_out
);
    typedef enum logic [3:0] {
        S_READ, S_UNL1, S_UNL2, S_PROG, S_ER1, S_ER2, S_ER3,
        S_ESECT, S_LOCK1, S_LOCK2, S_BEXIT
    } fbp_state_type;

    localparam logic [fbp_pkg::CNT_W-1:0] WIN_CYC =
        fbp_pkg::CNT_W'(ERASE_WIN_CYC);

    logic avd_q_r, we_q_r, ce_q_r, hw_q_r;
    logic [fbp_pkg::CNT_W-1:0] rp_cnt_r, rp_cnt_nxt, rec_cnt_r, rec_cnt_nxt;
    logic intr_r, intr_nxt;
    logic                         susp_r, susp_nxt, erasing_r, erasing_nxt;
    logic                         prog_busy_r, prog_busy_nxt;
    logic avd_rise, we_rise, ce_fall, quiet, clr_hit, wr_ok, abort_all;
    logic [fbp_pkg::CNT_W-1:0] ready_sel;

    // strobe edges and hardware reset timing
    assign avd_rise = pins.addr_valid_strobe_n & ~avd_q_r & ~pins.ce_n;
    assign we_rise  = pins.we_n & ~we_q_r;
    assign ce_fall  = ce_q_r & ~pins.ce_n;
    assign clr_hit  = ~hw_reset_n & (rp_cnt_r == fbp_pkg::RP_CYC);
    assign quiet    = ~hw_reset_n | (rec_cnt_r != '0);
    assign wr_ok = we_rise & ~pins.ce_n & pins.oe_n & ~quiet
                 & ~supply_lockout_level;
    assign abort_all = clr_hit | supply_lockout_level;

    always_comb begin
        rp_cnt_nxt  = rp_cnt_r;
        rec_cnt_nxt = rec_cnt_r;
        intr_nxt    = intr_r;
        ready_sel   = intr_r ? fbp_pkg::READY_BUSY_CYC
                             : fbp_pkg::READY_IDLE_CYC;
        if (!hw_reset_n) begin
            if (rp_cnt_r != fbp_pkg::RP_CYC) begin
                rp_cnt_nxt = rp_cnt_r + 1'b1;
            end
        end else begin
            rp_cnt_nxt = '0;
        end
        if (clr_hit && (erasing_r || prog_busy_r)) begin
            intr_nxt = 1'b1;
        end
        if (hw_reset_n && !hw_q_r) begin
            rec_cnt_nxt = (ready_sel > fbp_pkg::RH_CYC) ? ready_sel
                                                        : fbp_pkg::RH_CYC;
            intr_nxt    = 1'b0;
        end else if (rec_cnt_r != '0) begin
            rec_cnt_nxt = rec_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            avd_q_r   <= 1'b1;
            we_q_r    <= 1'b1;
            ce_q_r    <= 1'b1;
            hw_q_r    <= 1'b0;
            rp_cnt_r  <= '0;
            rec_cnt_r <= '0;
            intr_r    <= 1'b0;
        end else begin
            avd_q_r   <= pins.addr_valid_strobe_n;
            we_q_r    <= pins.we_n;
            ce_q_r    <= pins.ce_n;
            hw_q_r    <= hw_reset_n;
            rp_cnt_r  <= rp_cnt_nxt;
            rec_cnt_r <= rec_cnt_nxt;
            intr_r    <= intr_nxt;
        end
    end

    // sector map and protection
    logic [fbp_pkg::ADDR_W-1:0]   addr_r, addr_nxt;
    logic [fbp_pkg::NUM_SECT-1:0] lock_r, lock_nxt, locked_vec;
    logic [fbp_pkg::SECT_W-1:0]   sect_idx;
    logic                         bank_a;

    always_comb begin
        if (addr_r[fbp_pkg::ADDR_W-1:fbp_pkg::LARGE_LSB]
                == fbp_pkg::SMALL_REGION) begin
            sect_idx = fbp_pkg::SMALL_BASE + fbp_pkg::SECT_W'(
                addr_r[fbp_pkg::LARGE_LSB-1:fbp_pkg::SMALL_LSB]);
        end else begin
            sect_idx = {1'b0, addr_r[fbp_pkg::ADDR_W-1:fbp_pkg::LARGE_LSB]};
        end
    end
    assign bank_a = addr_r[fbp_pkg::ADDR_W-1:fbp_pkg::ADDR_W-2]
                  == fbp_pkg::BANK_A_SEL;

    for (genvar i = 0; i < fbp_pkg::NUM_SECT; i++) begin : g_lock
        localparam logic OUTER = (i == fbp_pkg::WP_SECT_LO)
                              || (i == fbp_pkg::WP_SECT_HI);
        assign locked_vec[i] = vpp_low | (~high_program_voltage
                             & (lock_r[i] | (~wp_n & OUTER)));
    end

    // command sequencer
    fbp_state_type                state_r, state_nxt;
    logic                         bypass_r, bypass_nxt, autosel_r, autosel_nxt;
    logic                         start_nxt;
    logic [fbp_pkg::NUM_SECT-1:0] emap_r, emap_nxt;
    logic [fbp_pkg::CNT_W-1:0]    win_r, win_nxt;
    fbp_pkg::fbp_op_type          op_r, op_nxt;
    logic [1:0]                   erase_bank;
    logic [7:0]                   wd;
    logic [10:0]                  wa;
    logic                         bypass_act, prog_ok;

    assign erase_bank = {|emap_r[fbp_pkg::NUM_SECT-1:fbp_pkg::BANK_A_FIRST],
                         |emap_r[fbp_pkg::BANK_A_FIRST-1:0]} & {2{erasing_r}};
    assign wd = pins.adq[7:0];
    assign wa = addr_r[10:0];
    assign bypass_act = bypass_r | high_program_voltage;
    assign prog_ok = ~locked_vec[sect_idx] & ~prog_busy_r
                   & ~(erase_bank[bank_a] & ~susp_r)
                   & ~(susp_r & emap_r[sect_idx]);

    always_comb begin
        state_nxt     = state_r;
        bypass_nxt    = bypass_r;
        autosel_nxt   = autosel_r;
        susp_nxt      = susp_r;
        erasing_nxt   = erasing_r;
        prog_busy_nxt = prog_busy_r;
        emap_nxt      = emap_r;
        win_nxt       = win_r;
        lock_nxt      = lock_r;
        op_nxt        = op_r;
        start_nxt     = 1'b0;
        addr_nxt      = avd_rise && !quiet
                      ? {pins.ahi, pins.adq} : addr_r;
        if (abort_all) begin
            state_nxt     = S_READ;
            bypass_nxt    = 1'b0;
            autosel_nxt   = 1'b0;
            susp_nxt      = 1'b0;
            erasing_nxt   = 1'b0;
            prog_busy_nxt = 1'b0;
            emap_nxt      = '0;
        end else begin
            // completion only from the core, never from deselect
            if (core_prog_done) begin
                prog_busy_nxt = 1'b0;
            end
            if (core_erase_done) begin
                erasing_nxt = 1'b0;
                susp_nxt    = 1'b0;
                emap_nxt    = '0;
            end
            if (state_r == S_ESECT && !wr_ok) begin
                if (win_r != '0) begin
                    win_nxt = win_r - 1'b1;
                end else begin
                    state_nxt   = S_READ;
                    erasing_nxt = |emap_r;
                    start_nxt   = |emap_r;
                    op_nxt      = '{fbp_pkg::OP_ERASE, addr_r, '0};
                end
            end
            if (wr_ok) begin
                state_nxt = S_READ;
                if (wd == fbp_pkg::CMD_RESET) begin
                    autosel_nxt = 1'b0;
                    if (state_r == S_ESECT) begin
                        emap_nxt = '0;
                    end
                end else begin
                    case (state_r)
                    S_READ: begin
                        if (bypass_act && wd == fbp_pkg::CMD_PROG) begin
                            state_nxt = S_PROG;
                        end else if (bypass_r
                                && wd == fbp_pkg::CMD_AUTOSEL) begin
                            state_nxt = S_BEXIT;
                        end else if (wd == fbp_pkg::UNL_DATA1
                                && wa == fbp_pkg::UNL_ADDR1) begin
                            state_nxt = S_UNL1;
                        end else if (wd == fbp_pkg::CMD_SUSP && erasing_r) begin
                            susp_nxt = 1'b1;
                        end else if (wd == fbp_pkg::CMD_RESUME && susp_r) begin
                            susp_nxt = 1'b0;
                        end else if (wd == fbp_pkg::CMD_LOCK) begin
                            state_nxt = S_LOCK1;
                        end
                    end
                    S_UNL1, S_ER1: begin
                        if (wd == fbp_pkg::UNL_DATA2
                                && wa == fbp_pkg::UNL_ADDR2) begin
                            state_nxt = (state_r == S_UNL1) ? S_UNL2 : S_ER2;
                        end
                    end
                    S_ER2: begin
                        if (wd == fbp_pkg::UNL_DATA1
                                && wa == fbp_pkg::UNL_ADDR1) begin
                            state_nxt = S_ER3;
                        end
                    end
                    S_UNL2: begin
                        if (wa == fbp_pkg::UNL_ADDR1) begin
                            if (wd == fbp_pkg::CMD_PROG) begin
                                state_nxt = S_PROG;
                            end else if (wd == fbp_pkg::CMD_ERASE
                                    && !erasing_r) begin
                                state_nxt = S_ER1;
                            end else if (wd == fbp_pkg::CMD_AUTOSEL) begin
                                autosel_nxt = 1'b1;
                            end else if (wd == fbp_pkg::CMD_BYPASS) begin
                                bypass_nxt = 1'b1;
                            end
                        end
                    end
                    S_PROG: begin
                        if (prog_ok) begin
                            prog_busy_nxt = 1'b1;
                            start_nxt     = 1'b1;
                            op_nxt = '{fbp_pkg::OP_PROG, addr_r, pins.adq};
                        end
                    end
                    S_ER3: begin
                        if (wd == fbp_pkg::CMD_CHIP
                                && wa == fbp_pkg::UNL_ADDR1) begin
                            emap_nxt    = ~locked_vec;
                            erasing_nxt = |(~locked_vec);
                            start_nxt   = |(~locked_vec);
                            op_nxt      = '{fbp_pkg::OP_ERASE, addr_r, '0};
                        end else if (wd == fbp_pkg::CMD_SECT) begin
                            emap_nxt[sect_idx] = ~locked_vec[sect_idx];
                            win_nxt   = WIN_CYC;
                            state_nxt = S_ESECT;
                        end
                    end
                    S_ESECT: begin
                        if (wd == fbp_pkg::CMD_SECT) begin
                            emap_nxt[sect_idx] = ~locked_vec[sect_idx];
                            win_nxt   = WIN_CYC;
                            state_nxt = S_ESECT;
                        end else begin
                            emap_nxt = '0;
                        end
                    end
                    S_LOCK1, S_LOCK2: begin
                        if (wd == fbp_pkg::CMD_LOCK) begin
                            if (state_r == S_LOCK2) begin
                                lock_nxt[sect_idx] =
                                    ~addr_r[fbp_pkg::LOCK_SEL_BIT];
                            end
                            state_nxt = S_LOCK2;
                        end
                    end
                    S_BEXIT: begin
                        if (wd == fbp_pkg::CMD_BYP_EXIT) begin
                            bypass_nxt = 1'b0;
                        end
                    end
                    default: state_nxt = S_READ;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r     <= S_READ;
            bypass_r    <= 1'b0;
            autosel_r   <= 1'b0;
            susp_r      <= 1'b0;
            erasing_r   <= 1'b0;
            prog_busy_r <= 1'b0;
            emap_r      <= '0;
            win_r       <= '0;
            lock_r      <= '1;
            op_r        <= '0;
            core_start  <= 1'b0;
            addr_r      <= '0;
        end else begin
            state_r     <= state_nxt;
            bypass_r    <= bypass_nxt;
            autosel_r   <= autosel_nxt;
            susp_r      <= susp_nxt;
            erasing_r   <= erasing_nxt;
            prog_busy_r <= prog_busy_nxt;
            emap_r      <= emap_nxt;
            win_r       <= win_nxt;
            lock_r      <= lock_nxt;
            op_r        <= op_nxt;
            core_start  <= start_nxt;
            addr_r      <= addr_nxt;
        end
    end

    // read path, access timing and automatic sleep
    logic [fbp_pkg::CNT_W-1:0]  acc_r, acc_nxt, sleep_r, sleep_nxt;
    logic [fbp_pkg::DATA_W-1:0] dout_r, dout_nxt;
    logic [7:0]                 id_byte;

    always_comb begin
        case (addr_r[7:0])
        fbp_pkg::ID_IDX_MAKER:  id_byte = fbp_pkg::MAKER_CODE;
        fbp_pkg::ID_IDX_DEVICE: id_byte = fbp_pkg::DEVICE_CODE;
        fbp_pkg::ID_IDX_LOCK:   id_byte = {7'h00, locked_vec[sect_idx]};
        default:                id_byte = 8'h00;
        endcase
        acc_nxt   = acc_r;
        sleep_nxt = sleep_r;
        dout_nxt  = dout_r;
        if (avd_rise && !quiet) begin
            acc_nxt   = fbp_pkg::ACC_CYC;
            sleep_nxt = '0;
        end else begin
            if (ce_fall && acc_r < fbp_pkg::CE_CYC) begin
                acc_nxt = fbp_pkg::CE_CYC;
            end else if (acc_r != '0) begin
                acc_nxt = acc_r - 1'b1;
            end
            if (sleep_r != fbp_pkg::SLEEP_CYC) begin
                sleep_nxt = sleep_r + 1'b1;
            end
        end
        // data only changes when a fresh access completes
        if (acc_r == fbp_pkg::CNT_W'(1)) begin
            dout_nxt = autosel_r ? {8'h00, id_byte} : array_rd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r   <= '0;
            sleep_r <= '0;
            dout_r  <= '0;
        end else begin
            acc_r   <= acc_nxt;
            sleep_r <= sleep_nxt;
            dout_r  <= dout_nxt;
        end
    end

    assign adq_out        = dout_r;
    assign adq_oe_n       = quiet | pins.ce_n | pins.oe_n | (acc_r != '0);
    assign array_rd_addr  = addr_r;
    assign core_op        = op_r;
    assign core_erase_map = emap_r;
    assign core_suspend   = susp_r;
    assign core_abort     = abort_all;
    assign sleep_active   = (sleep_r == fbp_pkg::SLEEP_CYC);
    assign standby_active = pins.ce_n & hw_reset_n;
    assign ready_out      = ~quiet;
endmodule

// file: hw/fbp_pkg.sv
// constants and carriers for the flash bus mode and protection controller
package fbp_pkg;
    localparam int ADDR_W   = 21;
    localparam int DATA_W   = 16;
    localparam int CNT_W    = 16;
    localparam int NUM_SECT = 71;
    localparam int SECT_W   = 7;
    // sectors at and above this index sit in the boot/parameter bank
    localparam int BANK_A_FIRST = 48;
    localparam int WP_SECT_LO   = 69;
    localparam int WP_SECT_HI   = 70;
    localparam int LOCK_SEL_BIT = 6;
    localparam int LARGE_LSB    = 15;
    localparam int SMALL_LSB    = 12;

    localparam logic [1:0] BANK_A_SEL = 2'h3;
    localparam logic [5:0] SMALL_REGION = 6'h3F;
    localparam logic [6:0] SMALL_BASE = 7'h3F;

    localparam logic [10:0] UNL_ADDR1 = 11'h555;
    localparam logic [10:0] UNL_ADDR2 = 11'h2AA;
    localparam logic [7:0] UNL_DATA1    = 8'hAA;
    localparam logic [7:0] UNL_DATA2    = 8'h55;
    localparam logic [7:0] CMD_PROG     = 8'hA0;
    localparam logic [7:0] CMD_ERASE    = 8'h80;
    localparam logic [7:0] CMD_CHIP     = 8'h10;
    localparam logic [7:0] CMD_SECT     = 8'h30;
    localparam logic [7:0] CMD_RESUME   = 8'h30;
    localparam logic [7:0] CMD_SUSP     = 8'hB0;
    localparam logic [7:0] CMD_AUTOSEL  = 8'h90;
    localparam logic [7:0] CMD_BYPASS   = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT = 8'h00;
    localparam logic [7:0] CMD_LOCK     = 8'h60;
    localparam logic [7:0] CMD_RESET    = 8'hF0;

    localparam logic [7:0] ID_IDX_MAKER  = 8'h00;
    localparam logic [7:0] ID_IDX_DEVICE = 8'h01;
    localparam logic [7:0] ID_IDX_LOCK   = 8'h02;
    // identity codes: arbitrary values
    localparam logic [7:0] MAKER_CODE  = 8'h5A;
    localparam logic [7:0] DEVICE_CODE = 8'hA5;

    localparam int CLK_PS          = 5000;
    localparam int T_ACC_NS        = 100;
    localparam int SLEEP_EXTRA_NS  = 60;
    localparam int T_CE_NS         = 100;
    localparam int T_RP_NS         = 50;
    localparam int T_RH_NS         = 50;
    localparam int T_READY_IDLE_NS = 500;
    localparam int T_READY_BUSY_NS = 20000;
    localparam int T_ERASE_WIN_NS  = 50000;

    localparam logic [CNT_W-1:0] ACC_CYC =
        CNT_W'((T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] CE_CYC =
        CNT_W'((T_CE_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] SLEEP_CYC =
        CNT_W'(((T_ACC_NS + SLEEP_EXTRA_NS) * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] RP_CYC =
        CNT_W'((T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] RH_CYC =
        CNT_W'((T_RH_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] READY_IDLE_CYC =
        CNT_W'((T_READY_IDLE_NS * 1000) / CLK_PS);
    localparam logic [CNT_W-1:0] READY_BUSY_CYC =
        CNT_W'((T_READY_BUSY_NS * 1000) / CLK_PS);
    localparam int ERASE_WIN_DEF = (T_ERASE_WIN_NS * 1000) / CLK_PS;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_PROG,
        OP_ERASE
    } fbp_op_kind_type;

    typedef struct packed {
        fbp_op_kind_type   kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbp_op_type;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              addr_valid_strobe_n;
        logic [4:0]        ahi;
        logic [DATA_W-1:0] adq;
    } fbp_pins_type;
endpackage

// file: tb/fbp_chk.sv
// port assertions for the flash bus controller
`timescale 1ns/1ps
module fbp_chk (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire fbp_pkg::fbp_pins_type pins,
    input wire logic                  hw_reset_n,
    input wire logic                  supply_lockout_level,
    input wire logic                  adq_oe_n,
    input wire fbp_pkg::fbp_op_type   core_op,
    input wire logic                  core_start,
    input wire logic                  core_abort,
    input wire logic                  standby_active,
    input wire logic                  ready_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_oe_float: assert property (pins.oe_n |-> adq_oe_n)
        else $error("data driven while output enable high");
    a_sel_float: assert property (pins.ce_n |-> adq_oe_n)
        else $error("data driven while deselected");
    a_standby_flag: assert property (
        standby_active == (pins.ce_n && hw_reset_n))
        else $error("standby flag wrong");
    a_rst_float: assert property (
        !hw_reset_n |-> adq_oe_n && !ready_out)
        else $error("active during hardware reset");
    a_abort_nostart: assert property (
        core_abort && $past(core_abort) |-> !core_start)
        else $error("start while aborted");
    a_lockout_abort: assert property (
        supply_lockout_level |-> core_abort)
        else $error("lockout without abort");
    a_start_kind: assert property (
        core_start |-> core_op.kind != fbp_pkg::OP_NONE)
        else $error("start without operation");
    a_start_pulse: assert property (core_start |=> !core_start)
        else $error("start longer than one cycle");
    c_start: cover property (core_start);
    c_drive: cover property (!adq_oe_n);
    c_abort: cover property (core_abort);
endmodule

// file: tb/fbp_core_model.sv
// array core: word data from address, slow done pulses
`timescale 1ns/1ps
module fbp_core_model #(
    parameter int DLY = 40
) (
    input wire logic                         sys_clk,
    input wire logic [fbp_pkg::ADDR_W-1:0]   rd_addr,
    output logic [fbp_pkg::DATA_W-1:0]       rd_data,
    input wire logic                         start,
    input wire fbp_pkg::fbp_op_type          op,
    output logic                             prog_done,
    output logic                             erase_done
);
    int cnt = 0;
    fbp_pkg::fbp_op_kind_type kind = fbp_pkg::OP_NONE;
    assign rd_data = ~rd_addr[15:0];
    initial begin
        prog_done = 1'b0;
        erase_done = 1'b0;
    end
    always @(posedge sys_clk) begin
        prog_done <= (cnt == 1) && (kind == fbp_pkg::OP_PROG);
        erase_done <= (cnt == 1) && (kind == fbp_pkg::OP_ERASE);
        cnt <= (start === 1'b1) ? DLY : (cnt > 0 ? cnt - 1 : 0);
        if (start === 1'b1) kind <= op.kind;
    end
endmodule

// file: tb/testbench.sv
// self-checking bench for the flash bus controller
`timescale 1ns/1ps
module testbench;
    logic                  sys_clk, rst_n, hw_reset_n, lockout;
    logic                  adq_oe_n, core_start, core_abort, ready_out;
    logic                  pdone, edone;
    logic [15:0]           adq_out, rd_data;
    logic [20:0]           rd_addr;
    fbp_pkg::fbp_pins_type pins;
    fbp_pkg::fbp_op_type   core_op;
    int                    n_errors = 0, n_checks = 0, n_start = 0;
    fbp_ctrl #(.ERASE_WIN_CYC(20)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
        .pins(pins), .hw_reset_n(hw_reset_n), .wp_n(1'b1),
        .high_program_voltage(1'b0), .vpp_low(1'b0),
        .supply_lockout_level(lockout), .adq_out(adq_out),
        .adq_oe_n(adq_oe_n), .array_rd_addr(rd_addr),
        .array_rd_data(rd_data), .core_op(core_op),
        .core_start(core_start), .core_erase_map(), .core_suspend(),
        .core_abort(core_abort), .core_prog_done(pdone),
        .core_erase_done(edone), .sleep_active(), .standby_active(),
        .ready_out(ready_out));
    fbp_core_model model (.sys_clk(sys_clk), .rd_addr(rd_addr),
        .rd_data(rd_data), .start(core_start), .op(core_op),
        .prog_done(pdone), .erase_done(edone));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (core_start === 1'b1) n_start++;
    task automatic chk(input string nm, input logic [39:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wt(ref logic s, input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            if (s === v) return;
            @(negedge sys_clk);
        end
        n_errors++;
        $display("unexpected wait exp %b got %b", v, s);
        report_and_stop();
    endtask
    task automatic adr(input logic [20:0] a);
        @(negedge sys_clk);
        pins.ce_n = 1'b0;
        pins.oe_n = 1'b1;
        pins.addr_valid_strobe_n = 1'b0;
        {pins.ahi, pins.adq} = a;
        @(negedge sys_clk);
        pins.addr_valid_strobe_n = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [20:0] a, input logic [15:0] d);
        adr(a);
        pins.adq = d;
        pins.we_n = 1'b0;
        @(negedge sys_clk);
        pins.we_n = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [20:0] a, input logic [15:0] e);
        adr(a);
        pins.oe_n = 1'b0;
        wt(adq_oe_n, 1'b0, 300);
        chk("read", adq_out, e);
        pins.oe_n = 1'b1;
    endtask
    task automatic prg(input logic [20:0] a, input logic [15:0] d);
        wr(21'h555, 16'h00AA);
        wr(21'h2AA, 16'h0055);
        wr(21'h555, 16'h00A0);
        wr(a, d);
    endtask
    task automatic t_id();
        wr(21'h555, 16'h00AA);
        wr(21'h2AA, 16'h0055);
        wr(21'h555, 16'h0090);
        rd(21'h0, {8'h00, fbp_pkg::MAKER_CODE});
        rd(21'h1, {8'h00, fbp_pkg::DEVICE_CODE});
        wr(21'h0, 16'h00F0);
        rd(21'h1234, 16'hEDCB);
        $display("test id done");
    endtask
    task automatic t_prog();
        repeat (3) wr(21'h40, 16'h0060);
        wr(21'h0, 16'h00F0);
        prg(21'h100, 16'hBEEF);
        wt(core_start, 1'b1, 20);
        chk("op", core_op, {fbp_pkg::OP_PROG, 21'h100, 16'hBEEF});
        rd(21'h180000, 16'hFFFF);
        wt(pdone, 1'b1, 100);
        wr(21'h555, 16'h00AA);
        wr(21'h2AA, 16'h0055);
        wr(21'h555, 16'h0020);
        wr(21'h555, 16'h00A0);
        wr(21'h200, 16'h1234);
        wt(core_start, 1'b1, 20);
        chk("bypass", core_op, {fbp_pkg::OP_PROG, 21'h200, 16'h1234});
        wt(pdone, 1'b1, 100);
        wr(21'h0, 16'h0090);
        wr(21'h0, 16'h0000);
        $display("test program done");
    endtask
    task automatic t_bad();
        int s;
        s = n_start;
        wr(21'h555, 16'h00AA);
        wr(21'h2AA, 16'h0054);
        wr(21'h555, 16'h00A0);
        wr(21'h100, 16'h1111);
        prg(21'h08000, 16'h2222);
        lockout = 1'b1;
        prg(21'h100, 16'h3333);
        chk("abort", core_abort, 1'b1);
        lockout = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("starts", n_start - s, 0);
        $display("test refuse done");
    endtask
    task automatic t_hwrst();
        prg(21'h300, 16'h5555);
        wt(core_start, 1'b1, 20);
        hw_reset_n = 1'b0;
        pins.ce_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        chk("oe", adq_oe_n, 1'b1);
        chk("abort", core_abort, 1'b1);
        hw_reset_n = 1'b1;
        repeat (150) @(negedge sys_clk);
        chk("ready", ready_out, 1'b0);
        wt(ready_out, 1'b1, 4200);
        rd(21'h10, 16'hFFEF);
        $display("test reset done");
    endtask
    initial begin
        rst_n = 1'b0;
        hw_reset_n = 1'b0;
        lockout = 1'b0;
        pins = '1;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        hw_reset_n = 1'b1;
        wt(ready_out, 1'b1, 300);
        t_id();
        t_prog();
        t_bad();
        t_hwrst();
        report_and_stop();
    end
endmodule
bind fbp_ctrl fbp_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins),
    .hw_reset_n(hw_reset_n), .supply_lockout_level(supply_lockout_level),
    .adq_oe_n(adq_oe_n), .core_op(core_op), .core_start(core_start),
    .core_abort(core_abort), .standby_active(standby_active),
    .ready_out(ready_out));
